// ===== ppsc_power_path_ctrl.sv
// top: power-path switch and converter control with apb registers
//
// Behaviour
// [R1] standby pin or bit turns converter off
// [R2] standby clear: state machine drives converter
// [R3] disable pin or bit forces battery switch off
// [R4] disable clear: switch follows combined decode
// [R5] each input is pin OR register setting; the frequency/cell config input is pin only
// [R6] reverse request: switch on, converter automatic
// [R7] nothing asserted: state machine controls both
// [R8] standby only: converter off, switch on
// [R9] disable and standby: both off
// [R10] high frequency allowed only with two cells
// [R11] disabled battery switch suspends charging
// [R12] pins resynchronised before decode
`timescale 1ns/10ps
module ppsc_power_path_ctrl (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // control pins
   input wire logic converter_standby_pin,
   input wire logic battery_switch_disable_pin,
   input wire logic reverse_supply_request_pin,
   input wire logic [1:0] frequency_cell_config_input,
   // requests from the power-path state machine
   input wire logic smQbatEnable,
   input wire logic smConvEnable,
   input wire logic smChargeEnable,
   // outputs to the power stage
   output logic battery_system_switch,
   output logic convEnable,
   output logic chargeEnable,
   output logic configInvalid
);
   import ppsc_pkg::*;

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic [1:0] rstSync_r;
   logic rstSyncN;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync_r <= 2'b00;
      end else begin
         rstSync_r <= {rstSync_r[0], 1'b1};
      end
   end
   assign rstSyncN = rstSync_r[1];

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [4:0] pinMeta_r, pinMeta_nxt, pinSync_r, pinSync_nxt;
   always_comb begin
      pinMeta_nxt = {frequency_cell_config_input, reverse_supply_request_pin,
         battery_switch_disable_pin, converter_standby_pin}; // [R12]
      pinSync_nxt = pinMeta_r;
   end
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         pinMeta_r <= 5'h00;
         pinSync_r <= 5'h00;
      end else begin
         pinMeta_r <= pinMeta_nxt;
         pinSync_r <= pinSync_nxt;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [1:0] ctrl_r, ctrl_nxt;
   logic [3:0] mode_r, mode_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic wrEn, rdEn, addrOk;
   logic [7:0] status;

   function automatic logic known(input logic [7:0] a);
      known = (a == REG_CTRL) || (a == REG_MODE) || (a == REG_STATUS);
   endfunction

   assign addrOk = known(paddr);
   assign wrEn = psel && penable && pwrite;
   assign rdEn = psel && !penable && !pwrite;

   always_comb begin
      ctrl_nxt = ctrl_r;
      mode_nxt = mode_r;
      prdata_nxt = prdata_r;
      if (wrEn && paddr == REG_CTRL) begin
         ctrl_nxt = pwdata[1:0];
      end
      if (wrEn && paddr == REG_MODE) begin
         mode_nxt = pwdata[MODE_LSB +: MODE_W];
      end
      if (rdEn) begin
         case (paddr)
            REG_CTRL: prdata_nxt = {30'h0000_0000, ctrl_r};
            REG_MODE: prdata_nxt = {28'h000_0000, mode_r};
            REG_STATUS: prdata_nxt = {24'h00_0000, status};
            default: prdata_nxt = APB_ZERO;
         endcase
      end
   end
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         ctrl_r <= CTRL_RESET;
         mode_r <= MODE_RESET;
         prdata_r <= APB_ZERO;
      end else begin
         ctrl_r <= ctrl_nxt;
         mode_r <= mode_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addrOk;

   // ----------------------------------------------------------------
   // combined inputs and decode
   // ----------------------------------------------------------------
   ppsc_ctl_if ctl ();
   assign ctl.otgReq = pinSync_r[2] || (mode_r == MODE_REVERSE); // [R5] [R6]
   assign ctl.batDis = pinSync_r[1] || ctrl_r[CTRL_BATDIS_BIT]; // [R5] [R3]
   assign ctl.standby = pinSync_r[0] || ctrl_r[CTRL_STANDBY_BIT]; // [R5] [R1]

   ppsc_decode u_decode (
      .clk(clk),
      .rstSyncN(rstSyncN),
      .ctl(ctl)
   );

   // ----------------------------------------------------------------
   // outputs to the power stage
   // ----------------------------------------------------------------
   logic battery_system_switch_r, battery_system_switch_nxt, conv_r, conv_nxt, chg_r, chg_nxt, cfgBad_r, cfgBad_nxt;

   function automatic logic apply(input logic [1:0] cmd, input logic sm);
      apply = (cmd == PPSC_SW_ON) ? 1'b1 : (cmd == PPSC_SW_OFF) ? 1'b0 : sm;
   endfunction

   always_comb begin
      battery_system_switch_nxt = apply(ctl.qbatCmd, smQbatEnable); // [R4]
      conv_nxt = apply(ctl.convCmd, smConvEnable); // [R2]
      // charging needs the battery switch available and the disable pin low
      chg_nxt = smChargeEnable && (ctl.qbatCmd != PPSC_SW_OFF) && !pinSync_r[1]; // [R11]
      // three cells at high frequency is an unsupported pairing
      cfgBad_nxt = pinSync_r[3 + CFG_HIFREQ_BIT] && pinSync_r[3 + CFG_3CELL_BIT]; // [R10]
   end
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         battery_system_switch_r <= 1'b0;
         conv_r <= 1'b0;
         chg_r <= 1'b0;
         cfgBad_r <= 1'b0;
      end else begin
         battery_system_switch_r <= battery_system_switch_nxt;
         conv_r <= conv_nxt;
         chg_r <= chg_nxt;
         cfgBad_r <= cfgBad_nxt;
      end
   end

   assign battery_system_switch = battery_system_switch_r;
   assign convEnable = conv_r;
   assign chargeEnable = chg_r;
   assign configInvalid = cfgBad_r;

   always_comb begin
      status = 8'h00;
      status[ST_OTG] = ctl.otgReq;
      status[ST_BATDIS] = ctl.batDis;
      status[ST_STANDBY] = ctl.standby;
      status[ST_BATTERY_SYSTEM_SWITCH_FORCE_ON] = (ctl.qbatCmd == PPSC_SW_ON);
      status[ST_BATTERY_SYSTEM_SWITCH_FORCE_OFF] = (ctl.qbatCmd == PPSC_SW_OFF);
      status[ST_CONV_OFF] = (ctl.convCmd == PPSC_SW_OFF);
      status[ST_CHG_SUSPEND] = !chg_r;
      status[ST_CFG_BAD] = cfgBad_r;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_BATTERY_SYSTEM_SWITCH_OFF_DIS: assert property (@(posedge clk) disable iff (!rstSyncN)
      (ctl.batDis && !ctl.otgReq) |-> ##2 !battery_system_switch) // [R3]
      else $error("battery switch not off while disabled");
   AST_CONV_OFF_CONVERTER_STANDBY_PIN: assert property (@(posedge clk) disable iff (!rstSyncN)
      (ctl.standby && !ctl.otgReq) |-> ##2 !convEnable) // [R1]
      else $error("converter not off in standby");
   AST_CONV_FOLLOWS_SM: assert property (@(posedge clk) disable iff (!rstSyncN)
      (!ctl.standby || ctl.otgReq) ##1 (!ctl.standby || ctl.otgReq)
      |=> convEnable == $past(smConvEnable)) // [R2]
      else $error("converter not following state machine");
   AST_BATTERY_SYSTEM_SWITCH_FOLLOWS_SM: assert property (@(posedge clk) disable iff (!rstSyncN)
      (!ctl.batDis && !ctl.standby && !ctl.otgReq) [*2]
      |=> battery_system_switch == $past(smQbatEnable)) // [R4]
      else $error("battery switch not following state machine");
   AST_NO_CHG_DIS: assert property (@(posedge clk) disable iff (!rstSyncN)
      pinSync_r[1] |=> !chargeEnable) // [R11]
      else $error("charging while battery switch disabled");
   AST_PIN_SYNC: assert property (@(posedge clk) disable iff (!rstSyncN)
      $rose(pinSync_r[2]) |-> ##2 battery_system_switch) // [R12] [R5]
      else $error("reverse pin not honoured after sync");
   AST_CFG_BAD: assert property (@(posedge clk) disable iff (!rstSyncN)
      (pinSync_r[3] && pinSync_r[4]) |=> configInvalid) // [R10]
      else $error("invalid frequency and cell pairing not flagged");
endmodule // ppsc_power_path_ctrl

// ===== ppsc_pkg.sv
// package: register map, field layout and codes of the power-path switch control
package ppsc_pkg;
   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_MODE = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTRL_STANDBY_BIT = 0;
   localparam int CTRL_BATDIS_BIT = 1;
   localparam int MODE_LSB = 0;
   localparam int MODE_W = 4;
   localparam int ST_OTG = 0;
   localparam int ST_BATDIS = 1;
   localparam int ST_STANDBY = 2;
   localparam int ST_BATTERY_SYSTEM_SWITCH_FORCE_ON = 3;
   localparam int ST_BATTERY_SYSTEM_SWITCH_FORCE_OFF = 4;
   localparam int ST_CONV_OFF = 5;
   localparam int ST_CHG_SUSPEND = 6;
   localparam int ST_CFG_BAD = 7;
   // ----------------------------------------------------------------
   // values after reset and codes
   // ----------------------------------------------------------------
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [3:0] MODE_RESET = 4'h0;
   localparam logic [3:0] MODE_REVERSE = 4'hA;
   localparam logic [31:0] APB_ZERO = 32'h0000_0000;
   // frequency/cell config: bit0 = high frequency, bit1 = three cells
   localparam int CFG_HIFREQ_BIT = 0;
   localparam int CFG_3CELL_BIT = 1;
   typedef enum logic [1:0] {
      PPSC_SW_AUTO = 2'b00,
      PPSC_SW_ON = 2'b01,
      PPSC_SW_OFF = 2'b11
   } ppsc_sw_e;
endpackage

// ===== ppsc_ctl_if.sv
// interface: combined control inputs and decoded switch commands
`timescale 1ns/10ps
interface ppsc_ctl_if;
   logic otgReq;
   logic batDis;
   logic standby;
   logic [1:0] qbatCmd;
   logic [1:0] convCmd;
   modport decoder (input otgReq, input batDis, input standby, output qbatCmd, output convCmd);
   modport top (output otgReq, output batDis, output standby, input qbatCmd, input convCmd);
endinterface // ppsc_ctl_if

// ===== ppsc_decode.sv
// module: registered decode of the switch and converter commands
`timescale 1ns/10ps
module ppsc_decode (
   // clock and reset
   input wire logic clk,
   input wire logic rstSyncN,
   // control
   ppsc_ctl_if.decoder ctl
);
   import ppsc_pkg::*;

   ppsc_sw_e battery_system_switch_r, battery_system_switch_nxt, conv_r, conv_nxt;

   always_comb begin
      if (ctl.otgReq) begin // [R6]
         battery_system_switch_nxt = PPSC_SW_ON;
         conv_nxt = PPSC_SW_AUTO;
      end else if (!ctl.batDis && !ctl.standby) begin // [R7] [R2] [R4]
         battery_system_switch_nxt = PPSC_SW_AUTO;
         conv_nxt = PPSC_SW_AUTO;
      end else if (!ctl.batDis) begin // [R8] [R1]
         battery_system_switch_nxt = PPSC_SW_ON;
         conv_nxt = PPSC_SW_OFF;
      end else if (!ctl.standby) begin // [R3]
         battery_system_switch_nxt = PPSC_SW_OFF;
         conv_nxt = PPSC_SW_AUTO;
      end else begin // [R9]
         battery_system_switch_nxt = PPSC_SW_OFF;
         conv_nxt = PPSC_SW_OFF;
      end
   end

   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         battery_system_switch_r <= PPSC_SW_AUTO;
         conv_r <= PPSC_SW_AUTO;
      end else begin
         battery_system_switch_r <= battery_system_switch_nxt;
         conv_r <= conv_nxt;
      end
   end

   assign ctl.qbatCmd = battery_system_switch_r;
   assign ctl.convCmd = conv_r;

   AST_OTG_WINS: assert property (@(posedge clk) disable iff (!rstSyncN)
      ctl.otgReq |=> (ctl.qbatCmd == PPSC_SW_ON && ctl.convCmd == PPSC_SW_AUTO)) // [R6]
      else $error("reverse request did not force switch on");
   AST_BOTH_OFF: assert property (@(posedge clk) disable iff (!rstSyncN)
      (!ctl.otgReq && ctl.batDis && ctl.standby) |=> (ctl.qbatCmd == PPSC_SW_OFF
      && ctl.convCmd == PPSC_SW_OFF)) // [R9]
      else $error("switch and converter not both off");
   AST_CONVERTER_STANDBY_PIN_BAT: assert property (@(posedge clk) disable iff (!rstSyncN)
      (!ctl.otgReq && !ctl.batDis && ctl.standby) |=> (ctl.qbatCmd == PPSC_SW_ON
      && ctl.convCmd == PPSC_SW_OFF)) // [R8]
      else $error("standby did not feed system from battery");
   AST_DIS_ONLY: assert property (@(posedge clk) disable iff (!rstSyncN)
      (!ctl.otgReq && ctl.batDis && !ctl.standby) |=> (ctl.qbatCmd == PPSC_SW_OFF
      && ctl.convCmd == PPSC_SW_AUTO)) // [R3]
      else $error("disable did not force battery switch off");
   AST_ALL_AUTO: assert property (@(posedge clk) disable iff (!rstSyncN)
      (!ctl.otgReq && !ctl.batDis && !ctl.standby) |=> (ctl.qbatCmd == PPSC_SW_AUTO
      && ctl.convCmd == PPSC_SW_AUTO)) // [R7]
      else $error("idle inputs did not leave state machine in control");
endmodule // ppsc_decode

// ===== ppsc_host_model.sv
// host controller model: apb master and control pins
`timescale 1ns/10ps
module ppsc_host_model (
   // clock and apb handshake
   input wire logic clk,
   input wire logic pready,
   // apb request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   // control pins
   output logic standbyPin,
   output logic disablePin,
   output logic reversePin,
   output logic [1:0] cfgPins
);
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {standbyPin, disablePin, reversePin, cfgPins} = '0;
   end
   // one transfer, request held until pready is sampled high
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data);
      @(posedge clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge clk);
      penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      psel <= 1'h0;
      penable <= 1'h0;
      // released lines must not keep the last value
      paddr <= ~addr;
      pwdata <= ~data;
   endtask
   task automatic setPins(input logic s, d, o, input logic [1:0] cfg);
      @(posedge clk);
      standbyPin <= s;
      disablePin <= d;
      reversePin <= o;
      cfgPins <= cfg;
   endtask
endmodule // ppsc_host_model

// ===== tb.sv
// testbench: power-path switch and converter control
`timescale 1ns/10ps
module tb;
   import ppsc_pkg::*;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, stbyPin, disPin, otgPin;
   logic smQ, smC, smCh, bss, convEn, chgEn, cfgBad, outChk, o, d, s, oP, dP, sP, oR, dR, sR;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, seed, r;
   logic [1:0] cfg;
   logic [3:0] mode;
   logic [32:0] rdQ[$];
   logic [3:0] outQ[$];
   int miscompares, samples_checked;
   ppsc_power_path_ctrl DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .converter_standby_pin(stbyPin), .battery_switch_disable_pin(disPin),
      .reverse_supply_request_pin(otgPin), .frequency_cell_config_input(cfg),
      .smQbatEnable(smQ), .smConvEnable(smC), .smChargeEnable(smCh),
      .battery_system_switch(bss), .convEnable(convEn), .chargeEnable(chgEn),
      .configInvalid(cfgBad));
   ppsc_host_model host (.clk(clk), .pready(pready), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .standbyPin(stbyPin),
      .disablePin(disPin), .reversePin(otgPin), .cfgPins(cfg));
   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end
   task automatic cmpRead(input logic [32:0] exp, input logic [32:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected read expected %h seen %h", exp, got);
      end
   endtask
   task automatic cmpOut(input logic [3:0] exp, input logic [3:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected outputs expected %h seen %h", exp, got);
      end
   endtask
   // ----------------------------------------------------------------
   // result watcher
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (psel && penable && pready && !pwrite && rdQ.size() > 0)
         cmpRead(rdQ.pop_front(), {pslverr, prdata});
      if (outChk && outQ.size() > 0)
         cmpOut(outQ.pop_front(), {bss, convEn, chgEn, cfgBad});
   end
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      rdQ.push_back(e);
      host.xfer(1'h0, a, 32'h0);
   endtask
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic final_report();
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      $display("unexpected watchdog expected done seen hang");
      final_report();
   end
   initial begin
      {rst_n, smQ, smC, smCh, outChk} = '0;
      seed = 32'h48CC;
      repeat (12) @(posedge clk);
      rst_n <= 1'h1;
      repeat (6) @(posedge clk);
      rd(REG_CTRL, 33'h0);
      rd(REG_MODE, 33'h0);
      // charging is off after reset, so the suspend flag reads set
      rd(REG_STATUS, 33'h0_0000_0040);
      rd(8'h0C, {1'h1, APB_ZERO});
      $display("test reset_values done");
      for (int i = 0; i < 32; i++) begin
         r = rnd();
         {s, d, o} = i[2:0];
         // each asserted input comes from pin, register or both
         oP = o & r[0];
         oR = o & (~r[0] | r[3]);
         dP = d & r[1];
         dR = d & (~r[1] | r[4]);
         sP = s & r[2];
         sR = s & (~r[2] | r[5]);
         mode = oR ? MODE_REVERSE : ((r[9:6] == 4'hA) ? 4'hB : r[9:6]);
         host.xfer(1'h1, REG_CTRL, {30'h0, dR, sR});
         host.xfer(1'h1, REG_MODE, {28'h0, mode});
         host.setPins(sP, dP, oP, r[11:10]);
         {smQ, smC, smCh} <= r[14:12];
         repeat (8) @(posedge clk);
         outQ.push_back({o | (~d & (s | r[14])), ~(~o & s) & r[13],
            r[12] & ~(dP | (~o & d)), r[11:10] == 2'h3});
         outChk <= 1'h1;
         @(posedge clk);
         outChk <= 1'h0;
         rd(REG_STATUS, {25'h0, r[11:10] == 2'h3, ~r[12] | dP | (~o & d), ~o & s, ~o & d,
            o | (~d & s), s, d, o});
         rd(REG_MODE, {29'h0, mode});
      end
      $display("test decode_table done");
      host.xfer(1'h1, 8'h0C, 32'hFFFF_FFFF);
      rd(REG_CTRL, {31'h0, dR, sR});
      $display("test unmapped_write done");
      final_report();
   end
endmodule // tb
